// ===== rtl/pcrr_pkg.sv
/*
 * Shared constants and types of the PHY clock and reset front end.
 * Assumes a single 250 MHz system clock and a synchronous active-high reset.
 */
package pcrr_pkg;

	// System clock period in picoseconds
	localparam int CLK_PERIOD_PS = 4000;

	// Least width of the PLL reset pulse, in nanoseconds
	localparam int PLL_PULSE_NS = 16;
	localparam int PLL_PULSE_CYC = (PLL_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Lock must stand this long before it is trusted, in nanoseconds
	localparam int LOCK_STABLE_NS = 32;
	localparam int LOCK_STABLE_CYC = (LOCK_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Number of synchroniser stages on every incoming reset and status level
	localparam int SYNC_STAGES = 2;

	// Bit positions of the synchronised input vector
	localparam int SYN_MASTER_BIT = 0;
	localparam int SYN_WARM_BIT = 1;
	localparam int SYN_LOCK_BIT = 2;
	localparam int SYN_WIDTH = 3;

	// Reset value of the synchronised inputs: all resets held, no lock
	localparam logic [2:0] SYN_RST_VAL = 3'h0;

	// Reset values of the output flops
	localparam logic PHY_RST_N_RST = 1'b0;
	localparam logic PLL_RST_RST = 1'b1;
	localparam logic REQ_N_RST = 1'b0;
	localparam logic [1:0] DIV_RST = 2'h0;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b000,
		ST_PULSE = 3'b001,
		ST_LOCKWAIT = 3'b010,
		ST_WARM = 3'b011,
		ST_RUN = 3'b100
	} pcrr_state_t;

	typedef struct packed {
		logic lock;
		logic warm;
		logic master;
	} pcrr_syn_t;

endpackage : pcrr_pkg

// ===== rtl/pcrr_sync.sv
/*
 * Multi-stage level synchroniser for a vector of independent bits.
 * Assumes the reset value is a constant and the inputs are quasi-static levels.
 */
module pcrr_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] stage [STAGES];
	logic [WIDTH-1:0] next_stage [STAGES];

	generate
		if (STAGES < 2) begin : g_bad_stages
			$error("pcrr_sync needs at least two stages");
		end
	endgenerate

	// Each stage only feeds the next one
	always_comb begin
		next_stage[0] = d;
		for (int i = 1; i < STAGES; i++) begin
			next_stage[i] = stage[i-1];
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < STAGES; i++) begin
			if (sys_rst) begin
				stage[i] <= RST_VAL;
			end else begin
				stage[i] <= next_stage[i];
			end
		end
	end

	assign q = stage[STAGES-1];

endmodule : pcrr_sync

// ===== rtl/pcrr_top.sv
/*
 * Clock and reset front end of a memory PHY: reset sequencing of the PLL and
 * the PHY domain, a divided PHY clock, a reprogramming clock and a gated
 * reprogramming enable.
 * Assumes the PLL itself sits outside and reports its lock on pll_lock.
 */
// Overview of operation
// RULE_01: Master reset low holds everything, PLL too.
// RULE_02: Internal resets come from synchronised master copies.
// RULE_03: Warm reset falling edge pulses PLL reset.
// RULE_04: Warm reset low holds PHY except PLL.
// RULE_05: PHY clock output; user signals follow it.
// RULE_06: Reference clock input feeds the PLL.
// RULE_07: PHY reset releases aligned to PHY clock.
// RULE_08: Reset request low whenever PLL unlocked.
// RULE_09: Request stays low through whole locking period.
// RULE_10: Outside logic should detect request falling edge.
// RULE_11: Outside logic keeps reprogramming gate low normally.
// RULE_12: Reprogram only in warm reset, request high.
// RULE_13: Gate high, reprogram, gate low, release warm.
// RULE_14: Gate works only with reprogramming option set.
// RULE_15: Separate clock output for reprogramming logic.
// RULE_16: PHY reset held until lock, resets released.
module pcrr_top #(
	parameter int PULSE_CYC = pcrr_pkg::PLL_PULSE_CYC,
	parameter int LOCK_CYC = pcrr_pkg::LOCK_STABLE_CYC,
	parameter bit REPROGRAM_PORTS_OPTION = 1'b0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic master_rst_n,
	input wire logic warm_rst_n,
	input wire logic pll_ref_clk,
	input wire logic pll_lock,
	input wire logic reprog_gate,
	output logic phy_clk,
	output logic phy_rst_n,
	output logic reset_request_n,
	output logic pll_rst,
	output logic pll_ref_out,
	output logic reprog_enable,
	output logic reconfig_clk
);

	localparam int PCW = $clog2(PULSE_CYC + 1);
	localparam int LCW = $clog2(LOCK_CYC + 1);
	localparam logic [PCW-1:0] PULSE_LAST = PCW'(PULSE_CYC - 1);
	localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_CYC - 1);

	generate
		if (PULSE_CYC < 2) begin : g_bad_pulse
			$error("pcrr_top needs a PLL pulse of at least two cycles");
		end
		if (LOCK_CYC < 1) begin : g_bad_lock
			$error("pcrr_top needs a lock filter of at least one cycle");
		end
	endgenerate

	logic [pcrr_pkg::SYN_WIDTH-1:0] syn_raw;
	pcrr_pkg::pcrr_syn_t syn;

	// RULE_02 synchronised master copy
	pcrr_sync #(
		.WIDTH(pcrr_pkg::SYN_WIDTH),
		.STAGES(pcrr_pkg::SYNC_STAGES),
		.RST_VAL(pcrr_pkg::SYN_RST_VAL)
	) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.d({pll_lock, warm_rst_n, master_rst_n}),
		.q(syn_raw)
	);

	assign syn = pcrr_pkg::pcrr_syn_t'(syn_raw);

	pcrr_pkg::pcrr_state_t state;
	pcrr_pkg::pcrr_state_t next_state;
	logic [PCW-1:0] pulse_cnt;
	logic [PCW-1:0] next_pulse_cnt;
	logic [LCW-1:0] lock_cnt;
	logic [LCW-1:0] next_lock_cnt;
	logic lock_ok;
	logic next_lock_ok;
	logic warm_prev;
	logic next_warm_prev;
	logic warm_fall;
	logic [1:0] div;
	logic [1:0] next_div;
	logic next_phy_clk;
	logic next_phy_rst_n;
	logic next_req_n;
	logic next_pll_rst;
	logic next_pll_ref_out;
	logic next_reprog_enable;
	logic next_reconfig_clk;

	assign warm_fall = warm_prev & ~syn.warm;

	// Where the sequencer goes once the PLL may run
	function automatic pcrr_pkg::pcrr_state_t after_pll(input logic warm);
		return warm ? pcrr_pkg::ST_LOCKWAIT : pcrr_pkg::ST_WARM;
	endfunction : after_pll

	// Sequencer
	always_comb begin
		next_state = state;
		next_pulse_cnt = pulse_cnt;
		next_warm_prev = syn.warm;
		case (state)
			pcrr_pkg::ST_HOLD: begin
				if (syn.master) begin
					next_state = after_pll(syn.warm);
				end
			end
			pcrr_pkg::ST_PULSE: begin
				if (pulse_cnt == PULSE_LAST) begin
					next_state = after_pll(syn.warm);
				end else begin
					next_pulse_cnt = pulse_cnt + PCW'(1);
				end
			end
			pcrr_pkg::ST_WARM: begin
				if (syn.warm) begin
					next_state = pcrr_pkg::ST_LOCKWAIT;
				end
			end
			pcrr_pkg::ST_LOCKWAIT: begin
				// RULE_16 run only when locked
				if (!syn.warm) begin
					next_state = pcrr_pkg::ST_WARM;
				end else if (lock_ok && syn.lock) begin
					next_state = pcrr_pkg::ST_RUN;
				end
			end
			pcrr_pkg::ST_RUN: begin
				if (!syn.warm) begin
					next_state = pcrr_pkg::ST_WARM;
				end else if (!syn.lock) begin
					next_state = pcrr_pkg::ST_LOCKWAIT;
				end
			end
			default: begin
				next_state = pcrr_pkg::ST_HOLD;
			end
		endcase
		// RULE_03 warm edge pulses PLL
		if (warm_fall && state != pcrr_pkg::ST_HOLD) begin
			next_state = pcrr_pkg::ST_PULSE;
			next_pulse_cnt = '0;
		end
		// RULE_01 master holds all
		if (!syn.master) begin
			next_state = pcrr_pkg::ST_HOLD;
			next_pulse_cnt = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= pcrr_pkg::ST_HOLD;
			pulse_cnt <= '0;
			warm_prev <= 1'b0;
		end else begin
			state <= next_state;
			pulse_cnt <= next_pulse_cnt;
			warm_prev <= next_warm_prev;
		end
	end

	// Lock filter and reset outputs
	always_comb begin
		next_lock_cnt = lock_cnt;
		next_lock_ok = lock_ok;
		next_pll_rst = (next_state == pcrr_pkg::ST_HOLD) || (next_state == pcrr_pkg::ST_PULSE);
		// RULE_09 lock counted while high, request held low
		if (!syn.lock || next_pll_rst) begin
			next_lock_cnt = '0;
			next_lock_ok = 1'b0;
		end else if (!lock_ok) begin
			if (lock_cnt == LOCK_LAST) begin
				next_lock_ok = 1'b1;
			end else begin
				next_lock_cnt = lock_cnt + LCW'(1);
			end
		end
		// RULE_08 request when unlocked
		next_req_n = next_lock_ok;
		// RULE_04 warm holds PHY
		next_phy_rst_n = 1'b0;
		if (next_state == pcrr_pkg::ST_RUN) begin
			// RULE_07 release on PHY clock rise
			next_phy_rst_n = phy_rst_n | ~phy_clk;
		end
		// RULE_14 gate needs option
		next_reprog_enable = REPROGRAM_PORTS_OPTION & reprog_gate & ~syn.warm & reset_request_n;
		// RULE_06 reference to PLL
		next_pll_ref_out = pll_ref_clk;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lock_cnt <= '0;
			lock_ok <= 1'b0;
			pll_rst <= pcrr_pkg::PLL_RST_RST;
			reset_request_n <= pcrr_pkg::REQ_N_RST;
			phy_rst_n <= pcrr_pkg::PHY_RST_N_RST;
			reprog_enable <= 1'b0;
			pll_ref_out <= 1'b0;
		end else begin
			lock_cnt <= next_lock_cnt;
			lock_ok <= next_lock_ok;
			pll_rst <= next_pll_rst;
			reset_request_n <= next_req_n;
			phy_rst_n <= next_phy_rst_n;
			reprog_enable <= next_reprog_enable;
			pll_ref_out <= next_pll_ref_out;
		end
	end

	// Clock dividers
	always_comb begin
		next_div = div + 2'h1;
		// RULE_05 PHY clock at half rate
		next_phy_clk = next_div[0];
		// RULE_15 reprogramming clock
		next_reconfig_clk = next_div[1];
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div <= pcrr_pkg::DIV_RST;
			phy_clk <= 1'b0;
			reconfig_clk <= 1'b0;
		end else begin
			div <= next_div;
			phy_clk <= next_phy_clk;
			reconfig_clk <= next_reconfig_clk;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_pll_pulse;
		pll_rst [*2];
	endsequence

	sequence s_held;
		pll_rst && !phy_rst_n;
	endsequence

	property p_master_hold;
		!syn.master |=> s_held;
	endproperty
	a_master_hold: assert property (p_master_hold) else $error("master reset did not hold"); // RULE_01

	property p_release_source;
		$rose(phy_rst_n) |-> $past(syn.master) && $past(syn.warm);
	endproperty
	a_release_source: assert property (p_release_source) else $error("reset left too early"); // RULE_02

	property p_warm_pulse;
		warm_fall && syn.master && state != pcrr_pkg::ST_HOLD |=> s_pll_pulse;
	endproperty
	a_warm_pulse: assert property (p_warm_pulse) else $error("no PLL pulse on warm edge"); // RULE_03

	property p_warm_hold;
		!syn.warm |=> !phy_rst_n;
	endproperty
	a_warm_hold: assert property (p_warm_hold) else $error("warm reset did not hold PHY"); // RULE_04

	property p_phy_clk;
		!$past(sys_rst) |-> phy_clk != $past(phy_clk);
	endproperty
	a_phy_clk: assert property (p_phy_clk) else $error("PHY clock stalled"); // RULE_05

	property p_ref;
		!$past(sys_rst) |-> pll_ref_out == $past(pll_ref_clk);
	endproperty
	a_ref: assert property (p_ref) else $error("reference not forwarded"); // RULE_06

	property p_release_edge;
		$rose(phy_rst_n) |-> phy_clk && !$past(phy_clk);
	endproperty
	a_release_edge: assert property (p_release_edge) else $error("release off PHY clock rise"); // RULE_07

	property p_unlock_req;
		!syn.lock |=> !reset_request_n;
	endproperty
	a_unlock_req: assert property (p_unlock_req) else $error("no request on lock loss"); // RULE_08

	property p_req_steady;
		!reset_request_n && syn.lock && !lock_ok && lock_cnt != LOCK_LAST |=> !reset_request_n;
	endproperty
	a_req_steady: assert property (p_req_steady) else $error("request glitched in locking"); // RULE_09

	property p_gate;
		reprog_enable |-> REPROGRAM_PORTS_OPTION && $past(reprog_gate) && !$past(syn.warm);
	endproperty
	a_gate: assert property (p_gate) else $error("reprogramming enable not gated"); // RULE_14

	property p_reconfig_clk;
		$rose(reconfig_clk) |=> reconfig_clk ##1 !reconfig_clk;
	endproperty
	a_reconfig_clk: assert property (p_reconfig_clk) else $error("reprogramming clock wrong"); // RULE_15

	property p_run_cond;
		phy_rst_n |-> $past(syn.master) && $past(syn.warm) && $past(syn.lock) && !pll_rst;
	endproperty
	a_run_cond: assert property (p_run_cond) else $error("PHY released without lock"); // RULE_16

endmodule : pcrr_top

// ===== bench/pcrr_pll_model.sv
/*
 * Stand-in for the PLL outside the PHY front end: loses lock in reset,
 * relocks after a bench-chosen delay, and drops lock on command.
 * Assumes pll_rst and the controls are synchronous to mclk.
 */
module pcrr_pll_model (
	input wire logic mclk,
	input wire logic pll_rst,
	input wire logic drop,
	input wire logic [4:0] lock_dly,
	output logic pll_lock
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] cnt = 5'h00;
	logic locked = 1'b0;

	assign pll_lock = locked;

	always @(posedge mclk) begin
		if (pll_rst || drop) begin
			cnt <= 5'h00;
			locked <= 1'b0;
		end else if (cnt < lock_dly) begin
			cnt <= cnt + 5'h01;
		end else begin
			locked <= 1'b1;
		end
	end
endmodule : pcrr_pll_model

// ===== bench/tb.sv
/*
 * Self-checking bench of the PHY clock and reset front end.
 * Assumes a 250 MHz mclk; a second instance without the option checks the gate refusal.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %0t %s", $time, m); end end

	localparam int PULSE = pcrr_pkg::PLL_PULSE_CYC;
	localparam int WD_CYC = 30000;

	logic mclk = 1'b0;
	logic sys_rst = 1'b1, master_rst_n = 1'b0, warm_rst_n = 1'b0, pll_ref_clk = 1'b0;
	logic reprog_gate = 1'b0, drop = 1'b0, run_chk = 1'b0, ref_q = 1'b0, pc_prev = 1'b0;
	logic [4:0] lock_dly = 5'h05;
	logic [3:0] lk_hist = 4'h0;
	logic [31:0] seed = 32'h1ae9cbf5;
	int n_fail = 0, checked = 0, cnt = 0;
	logic pll_lock, phy_clk, phy_rst_n, reset_request_n, pll_rst, pll_ref_out;
	logic reprog_enable, reprog_en_b;
	logic reconfig_clk, req_q = 1'b0;
	logic [1:0] rc_hist = 2'h0;
	int req_falls = 0, falls0 = 0;

	always #2 mclk = ~mclk;

	pcrr_top #(.REPROGRAM_PORTS_OPTION(1'b1)) DUT (.mclk(mclk), .sys_rst(sys_rst),
		.master_rst_n(master_rst_n), .warm_rst_n(warm_rst_n), .pll_ref_clk(pll_ref_clk),
		.pll_lock(pll_lock), .reprog_gate(reprog_gate), .phy_clk(phy_clk),
		.phy_rst_n(phy_rst_n), .reset_request_n(reset_request_n), .pll_rst(pll_rst),
		.pll_ref_out(pll_ref_out), .reprog_enable(reprog_enable), .reconfig_clk(reconfig_clk));
	pcrr_top DUT_b (.mclk(mclk), .sys_rst(sys_rst), .master_rst_n(master_rst_n),
		.warm_rst_n(warm_rst_n), .pll_ref_clk(pll_ref_clk), .pll_lock(pll_lock),
		.reprog_gate(reprog_gate), .phy_clk(), .phy_rst_n(), .reset_request_n(),
		.pll_rst(), .pll_ref_out(), .reprog_enable(reprog_en_b), .reconfig_clk());
	pcrr_pll_model PLL (.mclk(mclk), .pll_rst(pll_rst), .drop(drop), .lock_dly(lock_dly),
		.pll_lock(pll_lock));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	function automatic logic exp_en(input logic opt, input logic g, input logic w);
		return opt & g & ~w;
	endfunction : exp_en

	task close_out;
		if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task bring_up;
		@(negedge mclk);
		master_rst_n = 1'b1;
		warm_rst_n = 1'b1;
		drop = 1'b0;
		cnt = 0;
		while (phy_rst_n !== 1'b1 && cnt < 300) begin
			@(negedge mclk);
			cnt++;
		end
		`CHK(phy_rst_n, 1'b1, "phy reset stuck")
		`CHK(pll_lock, 1'b1, "phy up before lock")
		`CHK(reset_request_n, 1'b1, "request low when locked")
		`CHK(phy_clk, 1'b1, "release off phy clock rise")
	endtask : bring_up

	task gate_try(input logic exp);
		reprog_gate = 1'b1;
		repeat (4) @(negedge mclk);
		`CHK(reprog_enable, exp, "gate on")
		// gate back low for normal use
		reprog_gate = 1'b0;
		repeat (4) @(negedge mclk);
		`CHK(reprog_enable, 1'b0, "gate off")
	endtask : gate_try

	always @(posedge mclk) begin
		seed <= xs(seed);
		ref_q <= pll_ref_clk;
		lk_hist <= {lk_hist[2:0], pll_lock};
		// request seen by its falling edge
		req_q <= reset_request_n;
		if (req_q === 1'b1 && reset_request_n === 1'b0) req_falls <= req_falls + 1;
	end

	always @(negedge mclk) begin
		pll_ref_clk <= seed[0];
		if (run_chk) begin
			`CHK(pll_ref_out, ref_q, "reference forward")
			`CHK(phy_clk, ~pc_prev, "phy clock toggle")
			`CHK(reprog_en_b, 1'b0, "gate without option")
			if (lk_hist == 4'h0) `CHK(reset_request_n, 1'b0, "request while unlocked")
			`CHK(reconfig_clk, ~rc_hist[1], "reconfig clock pattern")
		end
		pc_prev = phy_clk;
		rc_hist = {rc_hist[0], reconfig_clk};
	end

	initial begin
		repeat (WD_CYC) @(posedge mclk);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK(phy_rst_n, 1'b0, "phy out of master hold")
		`CHK(pll_rst, 1'b1, "pll out of master hold")
		run_chk = 1'b1;
		for (int r = 0; r < 4; r++) begin
			lock_dly = {1'b0, seed[12:9]} + 5'h01;
			bring_up();
			gate_try(exp_en(1'b1, 1'b1, warm_rst_n));
			master_rst_n = 1'b0;
			repeat (4) @(negedge mclk);
			`CHK(pll_rst, 1'b1, "pll not held by master")
			`CHK(phy_rst_n, 1'b0, "phy not held by master")
			bring_up();
			warm_rst_n = 1'b0;
			cnt = 0;
			repeat (12) begin
				@(negedge mclk);
				if (pll_rst === 1'b1) cnt++;
			end
			`CHK(cnt, PULSE, "pll pulse length")
			`CHK(phy_rst_n, 1'b0, "phy not held by warm")
			cnt = 0;
			while (reset_request_n !== 1'b1 && cnt < 300) begin
				@(negedge mclk);
				cnt++;
			end
			`CHK(reset_request_n, 1'b1, "no relock in warm hold")
			// gate only in warm hold, request high
			gate_try(exp_en(1'b1, 1'b1, warm_rst_n));
			`CHK(phy_rst_n, 1'b0, "phy left warm hold")
			bring_up();
			falls0 = req_falls;
			drop = 1'b1;
			repeat (4) @(negedge mclk);
			`CHK(reset_request_n, 1'b0, "request on lock loss")
			`CHK(phy_rst_n, 1'b0, "phy kept on lock loss")
			@(negedge mclk);
			`CHK(req_falls, falls0 + 1, "request fall not seen")
		end
		close_out();
	end
endmodule : tb
